//--- shared/tcil_consts.svh
// Purpose: Offsets, bits, resets and counts of the timer.
// Assumes: Byte address is four times the index.
// Notes: Rule summary follows.
// Function
// - Timer runs and interrupts during wait.
// - Halt holds count; resumes after interrupt.
// - Halt capture edge arms; sets flag at exit.
// - First capture flag: capture, one-pulse start or PWM restart.
// - Compare events off in PWM; none wake halt.
// - One request line: flag, enable, unmasked.
// - Capture enable gates both capture flags.
// - Compare enable gates both compare flags.
// - Overflow enable gates overflow flag.
// - Second force copies second level out.
// - First force copies first level out.
// - Second level on match; first pin in modes.
// - First capture edge: 0 falling, 1 rising.
// - First level on first compare match.
// - Pin enables route outputs only.
// - One-pulse: capture edge starts single pulse.
// - PWM: width first compare, period second.
// - Clock select: div4, div2, div8, external.
// - No external pin: external select stops counter.
// - Second capture edge: 0 falling, 1 rising.
// - External clock edge: 0 falling, 1 rising.
// - Overflow flag on wrap to zero.
// - PWM second match reloads restart value.
`ifndef TCIL_CONSTS_SVH
`define TCIL_CONSTS_SVH
// Register indices
`define TCIL_IDX_CTL2 8'h11
`define TCIL_IDX_CTL1 8'h12
`define TCIL_IDX_STAT 8'h13
`define TCIL_IDX_CAP1H 8'h14
`define TCIL_IDX_CAP1L 8'h15
`define TCIL_IDX_CMP1H 8'h16
`define TCIL_IDX_CMP1L 8'h17
`define TCIL_IDX_CNTH 8'h18
`define TCIL_IDX_CNTL 8'h19
`define TCIL_IDX_ACNTH 8'h1A
`define TCIL_IDX_ACNTL 8'h1B
`define TCIL_IDX_CAP2H 8'h1C
`define TCIL_IDX_CAP2L 8'h1D
`define TCIL_IDX_CMP2H 8'h1E
`define TCIL_IDX_CMP2L 8'h1F
// Control one bits
`define TCIL_C1_CAP_IE 7
`define TCIL_C1_CMP_IE 6
`define TCIL_C1_OVF_IE 5
`define TCIL_C1_FORCE2 4
`define TCIL_C1_FORCE1 3
`define TCIL_C1_LVL2 2
`define TCIL_C1_EDGE1 1
`define TCIL_C1_LVL1 0
// Control two bits
`define TCIL_C2_PIN1 7
`define TCIL_C2_PIN2 6
`define TCIL_C2_OPM 5
`define TCIL_C2_PWM 4
`define TCIL_C2_CLKH 3
`define TCIL_C2_CLKL 2
`define TCIL_C2_EDGE2 1
`define TCIL_C2_EXT_CLK_EDGE 0
// Status bits
`define TCIL_S_CAP1 7
`define TCIL_S_CMP1 6
`define TCIL_S_OVF 5
`define TCIL_S_CAP2 4
`define TCIL_S_CMP2 3
`define TCIL_S_DIS 2
// Reset and restart values
`define TCIL_CNT_RESTART 16'hFFFC
`define TCIL_CAP_OPM 16'hFFFD
`define TCIL_CNT_MAX 16'hFFFF
`define TCIL_CMP_RESET 16'h8000
`define TCIL_CTL_RESET 8'h00
// Prescale ratios in pclk cycles
`define TCIL_DIV2 4'h2
`define TCIL_DIV4 4'h4
`define TCIL_DIV8 4'h8
`endif

//--- shared/tcil_pkg.sv
// Purpose: Types of the 16-bit timer.
// Assumes: Constants live in tcil_consts.svh.
// Notes: Clock choice encodes the two select bits in order.
package tcil_pkg;
   // Counter clock source
   typedef enum logic [1:0] {
      TCIL_CK_DIV4,
      TCIL_CK_DIV2,
      TCIL_CK_DIV8,
      TCIL_CK_EXT
   } tcil_clk_sel_t;
endpackage

//--- rtl/tcil_edge_sync.sv
// Purpose: Two-flop synchroniser with edge pulses for one pin.
// Assumes: Pin is asynchronous to pclk.
// Notes: Edge detect reads only the second and third flops.
`timescale 1ns/1ps
module tcil_edge_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   output logic rise,
   output logic fall
);
   logic meta_q; // First stage, read only by stage two
   logic sync_q; // Settled level
   logic last_q; // Previous settled level

   // Synchroniser chain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= pin;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign rise = sync_q & ~last_q;
   assign fall = ~sync_q & last_q;
endmodule

//--- rtl/tcil_prescale.sv
// Purpose: Counter tick generator from pclk or external edges.
// Assumes: External edges already synchronised.
// Notes: Frozen divider keeps its phase.
`timescale 1ns/1ps
`include "tcil_consts.svh"
module tcil_prescale #(
   parameter bit HAS_EXT = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire tcil_pkg::tcil_clk_sel_t sel,
   input wire logic freeze,
   input wire logic ext_edge,
   output logic tick
);
   import tcil_pkg::*;
   logic [3:0] div_q; // Cycle count within one prescale period
   logic [3:0] div_d;
   logic [3:0] ratio; // Selected division
   logic int_tick; // Internal period end

   assign ratio = (sel == TCIL_CK_DIV2) ? `TCIL_DIV2 :
                  (sel == TCIL_CK_DIV8) ? `TCIL_DIV8 : `TCIL_DIV4;
   assign int_tick = (div_q >= ratio - 4'h1);
   assign div_d = int_tick ? 4'h0 : div_q + 4'h1;
   // Without the pin the external choice never ticks
   assign tick = ~freeze & ((sel == TCIL_CK_EXT) ? (HAS_EXT & ext_edge)
                                                 : int_tick);

   // Divider runs only while unfrozen
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 4'h0;
      end else if (!freeze && sel != TCIL_CK_EXT) begin
         div_q <= div_d;
      end
   end
endmodule

//--- rtl/tcil_top.sv
// Purpose: 16-bit timer with two captures, two compares, one-pulse and PWM.
// Assumes: APB slave, zero wait states, byte registers in low data bits.
// Notes: halt_mode and wait_mode are levels from the power controller on pclk.
`timescale 1ns/1ps
`include "tcil_consts.svh"
module tcil_top #(
   parameter bit HAS_EXT = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic capture_in_first,
   input wire logic capture_in_second,
   input wire logic ext_count_clk_pin,
   output logic compare_out_first,
   output logic compare_out_first_en,
   output logic compare_out_second,
   output logic compare_out_second_en,
   input wire logic wait_mode,
   input wire logic halt_mode,
   input wire logic cpu_irq_mask,
   output logic timer_irq
);
   import tcil_pkg::*;

   // Control and status storage
   logic [7:0] ctl1_q; // timer_control_one
   logic [7:0] ctl2_q; // timer_control_two
   logic dis_q; // Software timer disable
   logic [4:0] flag_q; // cap1, cmp1, ovf, cap2, cmp2
   logic [4:0] flag_d;
   logic [4:0] armed_q; // Status read seen with flag set
   logic [4:0] armed_d;
   logic [15:0] cnt_q; // Free-running counter
   logic [15:0] cnt_d;
   logic [15:0] cap1_q; // First capture value
   logic [15:0] cap2_q; // Second capture value
   logic [15:0] cmp1_q; // First compare, as written
   logic [15:0] cmp2_q;
   logic [15:0] act1_q; // Compare values in use
   logic [15:0] act2_q;
   logic inh1_q; // High byte written, low pending
   logic inh2_q;
   logic out1_q; // Compare pin levels
   logic out2_q;
   logic [1:0] halt_arm_q; // Capture edges seen in halt
   logic halt_q; // Previous halt level
   logic [31:0] rdata_q; // Read data held for access phase

   // Control fields
   logic cap_ie, cmp_ie, ovf_ie;
   logic pwm_on, opm_on;
   tcil_clk_sel_t clk_sel;
   assign cap_ie = ctl1_q[`TCIL_C1_CAP_IE];
   assign cmp_ie = ctl1_q[`TCIL_C1_CMP_IE];
   assign ovf_ie = ctl1_q[`TCIL_C1_OVF_IE];
   assign pwm_on = ctl2_q[`TCIL_C2_PWM];
   assign opm_on = ctl2_q[`TCIL_C2_OPM] & ~pwm_on; // PWM takes precedence
   assign clk_sel = tcil_clk_sel_t'(ctl2_q[`TCIL_C2_CLKH:`TCIL_C2_CLKL]);

   // Pin synchronisers, one per input pin
   logic [2:0] pin_vec;
   logic [2:0] pin_rise;
   logic [2:0] pin_fall;
   assign pin_vec = {ext_count_clk_pin, capture_in_second, capture_in_first};
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_pin
         tcil_edge_sync u_sync (
            .pclk(pclk),
            .presetn(presetn),
            .pin(pin_vec[gi]),
            .rise(pin_rise[gi]),
            .fall(pin_fall[gi])
         );
      end
   endgenerate

   // Selected edges
   logic edge1, edge2, ext_edge;
   assign edge1 = ctl1_q[`TCIL_C1_EDGE1] ? pin_rise[0] : pin_fall[0];
   assign edge2 = ctl2_q[`TCIL_C2_EDGE2] ? pin_rise[1] : pin_fall[1];
   assign ext_edge = ctl2_q[`TCIL_C2_EXT_CLK_EDGE] ? pin_rise[2] : pin_fall[2];

   // Counter tick; wait mode does not freeze, halt and disable do
   logic freeze;
   logic tick;
   assign freeze = halt_mode | dis_q;
   tcil_prescale #(
      .HAS_EXT(HAS_EXT)
   ) u_presc (
      .pclk(pclk),
      .presetn(presetn),
      .sel(clk_sel),
      .freeze(freeze),
      .ext_edge(ext_edge),
      .tick(tick)
   );

   // APB decode
   logic [7:0] idx;
   logic idx_ok, addr_ok, setup, acc, wr, rd;
   assign idx = paddr[9:2];
   assign idx_ok = (idx >= `TCIL_IDX_CTL2) && (idx <= `TCIL_IDX_CMP2L);
   assign addr_ok = idx_ok && (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h0);
   assign setup = psel & ~penable;
   assign acc = psel & penable;
   assign wr = acc & pwrite & addr_ok;
   assign rd = acc & ~pwrite & addr_ok;
   assign pready = penable;
   assign pslverr = acc & ~addr_ok;
   assign prdata = rdata_q;

   // Accesses with side effects
   logic any_acc;
   logic stat_rd;
   logic [4:0] low_acc; // Low-byte access per flag
   logic w_ctl1, w_ctl2, w_stat, w_c1h, w_c1l, w_c2h, w_c2l, w_cntl;
   assign any_acc = acc & addr_ok;
   assign stat_rd = rd && idx == `TCIL_IDX_STAT;
   assign low_acc[4] = any_acc && idx == `TCIL_IDX_CAP1L;
   assign low_acc[3] = any_acc && idx == `TCIL_IDX_CMP1L;
   assign low_acc[2] = any_acc && idx == `TCIL_IDX_CNTL; // Alternate does not clear
   assign low_acc[1] = any_acc && idx == `TCIL_IDX_CAP2L;
   assign low_acc[0] = any_acc && idx == `TCIL_IDX_CMP2L;
   assign w_ctl1 = wr && idx == `TCIL_IDX_CTL1;
   assign w_ctl2 = wr && idx == `TCIL_IDX_CTL2;
   assign w_stat = wr && idx == `TCIL_IDX_STAT;
   assign w_c1h = wr && idx == `TCIL_IDX_CMP1H;
   assign w_c1l = wr && idx == `TCIL_IDX_CMP1L;
   assign w_c2h = wr && idx == `TCIL_IDX_CMP2H;
   assign w_c2l = wr && idx == `TCIL_IDX_CMP2L;
   assign w_cntl = wr && (idx == `TCIL_IDX_CNTL || idx == `TCIL_IDX_ACNTL);

   // Read mux
   logic [7:0] stat_byte;
   logic [7:0] rbyte;
   assign stat_byte = {flag_q[4:2], flag_q[1:0], dis_q, 2'b00};
   always_comb begin
      case (idx)
         `TCIL_IDX_CTL2: rbyte = ctl2_q;
         `TCIL_IDX_CTL1: rbyte = ctl1_q;
         `TCIL_IDX_STAT: rbyte = stat_byte;
         `TCIL_IDX_CAP1H: rbyte = cap1_q[15:8];
         `TCIL_IDX_CAP1L: rbyte = cap1_q[7:0];
         `TCIL_IDX_CMP1H: rbyte = cmp1_q[15:8];
         `TCIL_IDX_CMP1L: rbyte = cmp1_q[7:0];
         `TCIL_IDX_CNTH, `TCIL_IDX_ACNTH: rbyte = cnt_q[15:8];
         `TCIL_IDX_CNTL, `TCIL_IDX_ACNTL: rbyte = cnt_q[7:0];
         `TCIL_IDX_CAP2H: rbyte = cap2_q[15:8];
         `TCIL_IDX_CAP2L: rbyte = cap2_q[7:0];
         `TCIL_IDX_CMP2H: rbyte = cmp2_q[15:8];
         `TCIL_IDX_CMP2L: rbyte = cmp2_q[7:0];
         default: rbyte = 8'h00;
      endcase
   end

   // Timer events
   logic halt_exit;
   logic match1, match2, wrap;
   logic cap1_ev, cap2_ev, opm_start, pwm_end;
   assign halt_exit = halt_q & ~halt_mode; // Interrupt wake; reset wake resets all
   assign match1 = tick & ~inh1_q & (cnt_q == act1_q);
   assign match2 = tick & ~inh2_q & (cnt_q == act2_q);
   assign wrap = tick & (cnt_q == `TCIL_CNT_MAX);
   assign pwm_end = pwm_on & match2;
   assign opm_start = opm_on & ~halt_mode & edge1;
   // Capture 1 pin does not capture in PWM and one-pulse modes
   assign cap1_ev = (~pwm_on & ~opm_on & ~halt_mode & edge1)
                  | (halt_exit & halt_arm_q[0]);
   assign cap2_ev = (~halt_mode & edge2) | (halt_exit & halt_arm_q[1]);

   // Counter next value
   always_comb begin
      cnt_d = cnt_q;
      if (w_cntl || opm_start || pwm_end) begin
         cnt_d = `TCIL_CNT_RESTART;
      end else if (tick) begin
         cnt_d = cnt_q + 16'h0001;
      end
   end

   // Flag set and clear; a set in the clearing cycle wins
   logic [4:0] flag_set;
   assign flag_set[4] = cap1_ev | opm_start | pwm_end;
   assign flag_set[3] = match1 & ~pwm_on & ~opm_on;
   assign flag_set[2] = wrap;
   assign flag_set[1] = cap2_ev;
   assign flag_set[0] = match2 & ~pwm_on;
   always_comb begin
      armed_d = armed_q;
      flag_d = flag_q;
      for (int i = 0; i < 5; i++) begin
         if (stat_rd && flag_q[i]) begin
            armed_d[i] = 1'b1;
         end else if (low_acc[i]) begin
            armed_d[i] = 1'b0;
         end
         if (flag_set[i]) begin
            flag_d[i] = 1'b1;
         end else if (low_acc[i] && armed_q[i]) begin
            flag_d[i] = 1'b0;
         end
      end
   end

   // Shared request line; masked by the CPU interrupt mask
   logic irq_any;
   assign irq_any = (cap_ie & (flag_q[4] | flag_q[1]))
                  | (cmp_ie & (flag_q[3] | flag_q[0]))
                  | (ovf_ie & flag_q[2]);
   // Wait mode leaves this path live so it can wake the CPU; no halt wake
   assign timer_irq = irq_any & ~cpu_irq_mask;

   // Compare pin levels
   logic lvl1, lvl2, out1_d, out2_d;
   assign lvl1 = ctl1_q[`TCIL_C1_LVL1];
   assign lvl2 = ctl1_q[`TCIL_C1_LVL2];
   always_comb begin
      out1_d = out1_q;
      out2_d = out2_q;
      if (pwm_on) begin
         if (pwm_end) begin
            out1_d = lvl2;
         end else if (match1) begin
            out1_d = lvl1;
         end
      end else if (opm_on) begin
         if (opm_start) begin
            out1_d = lvl2;
         end else if (match1) begin
            out1_d = lvl1;
         end
      end else begin
         if (match1) begin
            out1_d = lvl1;
         end
         if (match2) begin
            out2_d = lvl2;
         end
      end
      if (ctl1_q[`TCIL_C1_FORCE1]) begin
         out1_d = lvl1;
      end
      if (ctl1_q[`TCIL_C1_FORCE2]) begin
         out2_d = lvl2;
      end
   end

   // Pins routed only when enabled; disable parks them
   assign compare_out_first_en = ctl2_q[`TCIL_C2_PIN1] & ~dis_q;
   assign compare_out_second_en = ctl2_q[`TCIL_C2_PIN2] & ~dis_q;
   assign compare_out_first = out1_q & compare_out_first_en;
   assign compare_out_second = out2_q & compare_out_second_en;

   // Control registers and read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl1_q <= `TCIL_CTL_RESET;
         ctl2_q <= `TCIL_CTL_RESET;
         dis_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         if (w_ctl1) begin
            ctl1_q <= pwdata[7:0];
         end
         if (w_ctl2) begin
            ctl2_q <= pwdata[7:0];
         end
         if (w_stat) begin
            dis_q <= pwdata[`TCIL_S_DIS];
         end
         if (setup) begin
            rdata_q <= {24'h00_0000, rbyte};
         end
      end
   end

   // Counter, flags and pin levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= `TCIL_CNT_RESTART;
         flag_q <= 5'h00;
         armed_q <= 5'h00;
         out1_q <= 1'b0;
         out2_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         flag_q <= flag_d;
         armed_q <= armed_d;
         out1_q <= out1_d;
         out2_q <= out2_d;
      end
   end

   // Capture values; one-pulse start loads a fixed value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap1_q <= 16'h0000;
         cap2_q <= 16'h0000;
      end else begin
         if (opm_start) begin
            cap1_q <= `TCIL_CAP_OPM;
         end else if (cap1_ev) begin
            cap1_q <= cnt_q;
         end
         if (cap2_ev) begin
            cap2_q <= cnt_q;
         end
      end
   end

   // Halt tracking and capture arming
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_q <= 1'b0;
         halt_arm_q <= 2'b00;
      end else begin
         halt_q <= halt_mode;
         if (halt_exit) begin
            halt_arm_q <= 2'b00;
         end else if (halt_mode) begin
            // Capture 1 arms only in plain capture mode
            if (edge1 && !pwm_on && !opm_on) begin
               halt_arm_q[0] <= 1'b1;
            end
            if (edge2) begin
               halt_arm_q[1] <= 1'b1;
            end
         end
      end
   end

   // Compare registers; high write inhibits until low write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp1_q <= `TCIL_CMP_RESET;
         cmp2_q <= `TCIL_CMP_RESET;
         inh1_q <= 1'b0;
         inh2_q <= 1'b0;
      end else begin
         if (w_c1h) begin
            cmp1_q[15:8] <= pwdata[7:0];
            inh1_q <= 1'b1;
         end
         if (w_c1l) begin
            cmp1_q[7:0] <= pwdata[7:0];
            inh1_q <= 1'b0;
         end
         if (w_c2h) begin
            cmp2_q[15:8] <= pwdata[7:0];
            inh2_q <= 1'b1;
         end
         if (w_c2l) begin
            cmp2_q[7:0] <= pwdata[7:0];
            inh2_q <= 1'b0;
         end
      end
   end

   // Active compare values; PWM reloads only at period end to avoid spikes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act1_q <= `TCIL_CMP_RESET;
         act2_q <= `TCIL_CMP_RESET;
      end else if (!pwm_on || pwm_end) begin
         act1_q <= cmp1_q;
         act2_q <= cmp2_q;
      end
   end

   // Wait mode needs no logic: the timer simply keeps running
   logic unused_wait;
   assign unused_wait = wait_mode;
endmodule

//--- tb/tcil_asserts.sv
// Purpose: Port checks for the timer.
// Assumes: Control bytes shadowed from APB writes.
// Notes: Forced levels checked in plain mode only.
`timescale 1ns/1ps
`include "tcil_consts.svh"
module tcil_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic compare_out_first,
   input wire logic compare_out_first_en,
   input wire logic compare_out_second,
   input wire logic compare_out_second_en,
   input wire logic cpu_irq_mask,
   input wire logic timer_irq
);
   localparam logic [31:0] A1 = `TCIL_IDX_CTL1 * 4;
   localparam logic [31:0] A2 = `TCIL_IDX_CTL2 * 4;
   localparam logic [31:0] AS = `TCIL_IDX_STAT * 4;
   logic [7:0] c1_q; // Shadow control one
   logic [7:0] c2_q; // Shadow control two
   logic dis_q; // Shadow disable bit
   wire wr_w = psel && penable && pwrite; // Write lands
   wire rd_w = psel && penable && !pwrite; // Read completes
   wire plain_w = c2_q[5:4] == 2'b00 && !dis_q; // No pulse modes
   wire f1_w = c1_q[3] && c2_q[7] && plain_w; // First pin forced
   wire f2_w = c1_q[4] && c2_q[6] && plain_w; // Second pin forced
   wire off1_w = !c2_q[7] || dis_q; // First pin released
   wire off2_w = !c2_q[6] || dis_q; // Second pin released
   // Shadow follows writes at the access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         c1_q <= 8'h00;
         c2_q <= 8'h00;
         dis_q <= 1'b0;
      end else if (wr_w) begin
         if (paddr == A1) c1_q <= pwdata[7:0];
         if (paddr == A2) c2_q <= pwdata[7:0];
         if (paddr == AS) dis_q <= pwdata[`TCIL_S_DIS];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   irq_masked_a: assert property (cpu_irq_mask |-> !timer_irq)
      else $error("irq while masked");
   irq_gated_a: assert property (c1_q[7:5] == 3'b000 |-> !timer_irq)
      else $error("irq with enables clear");
   pin_one_off_a: assert property (off1_w [*2] |->
      !compare_out_first_en && !compare_out_first) else $error("first pin not released");
   pin_two_off_a: assert property (off2_w ##1 off2_w |->
      !compare_out_second_en && !compare_out_second) else $error("second pin not released");
   force_one_a: assert property (f1_w ##1 (f1_w && $stable(c1_q)) |->
      compare_out_first == c1_q[0] && compare_out_first_en) else $error("first force lost");
   force_two_a: assert property (f2_w ##1 (f2_w && $stable(c1_q)) |->
      compare_out_second == c1_q[2] && compare_out_second_en) else $error("second force lost");
   ctl_one_rd_a: assert property (rd_w && paddr == A1 |->
      prdata == {24'h00_0000, $past(c1_q)}) else $error("control one readback");
   ctl_two_rd_a: assert property (rd_w && paddr == A2 |->
      prdata == {24'h00_0000, $past(c2_q)}) else $error("control two readback");
endmodule
bind tcil_top tcil_asserts u_chk (.*);

//--- tb/tcil_pins.sv
// Purpose: Timer far side: capture pins, external clock, pads.
// Assumes: Pins move just after a pclk edge.
// Notes: External clock moves only on request.
`timescale 1ns/1ps
module tcil_pins (
   input wire logic pclk,
   input wire logic compare_out_first,
   input wire logic compare_out_first_en,
   input wire logic compare_out_second,
   input wire logic compare_out_second_en,
   output logic capture_in_first,
   output logic capture_in_second,
   output logic ext_count_clk_pin,
   output logic pad_first,
   output logic pad_second
);
   // Board pull-ups hold a released pad high
   assign pad_first = compare_out_first_en ? compare_out_first : 1'b1;
   assign pad_second = compare_out_second_en ? compare_out_second : 1'b1;
   // Quiet pins at time zero
   initial begin
      capture_in_first = 1'b0;
      capture_in_second = 1'b0;
      ext_count_clk_pin = 1'b0;
   end
   // Move one pin: 0 first capture, 1 second capture, 2 external clock
   task automatic drive(input int k, input logic v);
      @(posedge pclk);
      case (k)
         0: capture_in_first <= v;
         1: capture_in_second <= v;
         default: ext_count_clk_pin <= v;
      endcase
   endtask
endmodule

//--- tb/testbench.sv
// Purpose: Self-checking timer bench.
// Assumes: APB answer comes when pready is high.
// Notes: Tasks return at a falling edge, so checks see settled values.
`timescale 1ns/1ps
`include "tcil_consts.svh"
module testbench;
   logic pclk = 1'b0, presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, timer_irq;
   logic capture_in_first, capture_in_second, ext_count_clk_pin, pad_first, pad_second;
   logic compare_out_first, compare_out_first_en, compare_out_second, compare_out_second_en;
   logic wait_mode = 1'b0, halt_mode = 1'b0, cpu_irq_mask = 1'b0;
   logic [31:0] rd; // Read data
   logic err, lv, hit; // Error answer, pin level, expected hit
   logic [7:0] v; // Held count
   int mismatches = 0;
   int compares = 0;
   logic [7:0] pat [2] = '{8'hA5, 8'h5A}; // Readback patterns
   logic [7:0] fl [2] = '{8'h80, 8'h10}; // Capture flag bits
   int dv [3] = '{`TCIL_DIV4, `TCIL_DIV2, `TCIL_DIV8}; // Divide per select
   always #2.5 pclk = ~pclk;
   tcil_top u_dut (.*);
   tcil_pins u_pins (.*);
   // One APB transfer, answer taken at the rising edge that sees pready
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {22'h00_0000, idx, 2'b00};
      pwdata <= {24'h00_0000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (!pready && n < 64);
      if (!pready) mismatches++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask
   // Exact compare, four-state
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Read and compare the masked bits
   task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] m,
      input logic [7:0] e);
      apb(1'b0, idx, 8'h00);
      chk(nm, 32'(e), rd & 32'(m));
   endtask
   // Count compare, two ticks of slack
   task automatic near(input string nm, input logic [7:0] e, input logic [7:0] g);
      logic [7:0] d;
      d = g - e + 8'h02;
      chk(nm, e, ((d <= 8'h04) === 1'b1) ? e : g);
   endtask
   // Wait n edges, then a falling edge
   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   // Verdict and end of run
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Hang guard, far past the run length
   initial begin
      repeat (40000) @(posedge pclk);
      mismatches++;
      stop_test();
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rchk("ctl1 reset", `TCIL_IDX_CTL1, 8'hFF, 8'h00);
      rchk("ctl2 reset", `TCIL_IDX_CTL2, 8'hFF, 8'h00);
      foreach (pat[i]) begin
         apb(1'b1, `TCIL_IDX_CTL1, pat[i]);
         apb(1'b1, `TCIL_IDX_CTL2, ~pat[i]);
         rchk("ctl1 readback", `TCIL_IDX_CTL1, 8'hFF, pat[i]);
         rchk("ctl2 readback", `TCIL_IDX_CTL2, 8'hFF, ~pat[i]);
      end
      apb(1'b1, `TCIL_IDX_CTL1, 8'h00);
      apb(1'b1, `TCIL_IDX_CTL2, 8'h00);
      // Unmapped index: error answer, no data
      apb(1'b0, 8'h10, 8'h00);
      chk("unmapped err", 1, err);
      chk("unmapped data", 0, rd);
      // Wrap flag, its enable, mask and clear
      apb(1'b1, `TCIL_IDX_CNTL, 8'h00);
      settle(40);
      rchk("overflow flag", `TCIL_IDX_STAT, 8'h20, 8'h20);
      chk("irq ovf off", 0, timer_irq);
      apb(1'b1, `TCIL_IDX_CTL1, 8'h20);
      chk("irq ovf on", 1, timer_irq);
      @(posedge pclk);
      cpu_irq_mask <= 1'b1;
      settle(0);
      chk("irq masked", 0, timer_irq);
      @(posedge pclk);
      cpu_irq_mask <= 1'b0;
      apb(1'b0, `TCIL_IDX_STAT, 8'h00);
      apb(1'b0, `TCIL_IDX_CNTL, 8'h00);
      chk("irq ovf cleared", 0, timer_irq);
      // Count rate per divide select
      for (int s = 0; s < 3; s++) begin
         apb(1'b1, `TCIL_IDX_CTL2, 8'(s << 2));
         apb(1'b1, `TCIL_IDX_CNTL, 8'h00);
         repeat (64) @(posedge pclk);
         apb(1'b0, `TCIL_IDX_CNTL, 8'h00);
         near("count rate", 8'hFC + 8'(66 / dv[s]), rd[7:0]);
      end
      // External clock counts selected edge
      for (int e = 0; e < 2; e++) begin
         apb(1'b1, `TCIL_IDX_CTL2, 8'h0C | 8'(e));
         apb(1'b1, `TCIL_IDX_CNTL, 8'h00);
         u_pins.drive(2, 1'b1);
         settle(8);
         rchk("ext rise", `TCIL_IDX_CNTL, 8'hFF, 8'hFC + 8'(e));
         u_pins.drive(2, 1'b0);
         settle(8);
         rchk("ext fall", `TCIL_IDX_CNTL, 8'hFF, 8'hFD);
      end
      // Forced levels; released pads float high
      apb(1'b1, `TCIL_IDX_CTL2, 8'hC0);
      for (int l = 1; l < 5; l += 3) begin
         apb(1'b1, `TCIL_IDX_CTL1, 8'h18 | 8'(l));
         settle(2);
         chk("first pin", l & 1, pad_first);
         chk("second pin", l >> 2, pad_second);
      end
      apb(1'b1, `TCIL_IDX_CTL2, 8'h00);
      chk("released pads", 2'b11, {pad_first, pad_second});
      // Capture edges flag, also in wait
      @(posedge pclk);
      wait_mode <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         for (int e = 0; e < 2; e++) begin
            apb(1'b1, `TCIL_IDX_CTL1, 8'h80 | 8'(k == 0 ? e << 1 : 0));
            apb(1'b1, `TCIL_IDX_CTL2, 8'(k == 1 ? e << 1 : 0));
            repeat (2) begin
               lv = k ? !capture_in_second : !capture_in_first;
               u_pins.drive(k, lv);
               settle(8);
               hit = (lv == e);
               rchk("capture flag", `TCIL_IDX_STAT, fl[k], hit ? fl[k] : 8'h00);
               chk("capture irq", hit, timer_irq);
               apb(1'b0, k ? `TCIL_IDX_CAP2L : `TCIL_IDX_CAP1L, 8'h00);
               chk("capture clear", 0, timer_irq);
            end
         end
      end
      @(posedge pclk);
      wait_mode <= 1'b0;
      // Halt holds count and capture until wake
      apb(1'b1, `TCIL_IDX_CTL1, 8'h82);
      @(posedge pclk);
      halt_mode <= 1'b1;
      apb(1'b0, `TCIL_IDX_CNTL, 8'h00);
      v = rd[7:0];
      settle(40);
      rchk("held count", `TCIL_IDX_CNTL, 8'hFF, v);
      u_pins.drive(0, 1'b1);
      settle(8);
      rchk("capture in halt", `TCIL_IDX_STAT, 8'h80, 8'h00);
      @(posedge pclk);
      halt_mode <= 1'b0;
      settle(4);
      rchk("capture at wake", `TCIL_IDX_STAT, 8'h80, 8'h80);
      rchk("captured count", `TCIL_IDX_CAP1L, 8'hFF, v);
      stop_test();
   end
endmodule
